// File: verilog/lwf_defs.svh
// Offsets, field positions, reset values and timing counts of the
// segment display waveform block.
// Assumes a 32-bit APB slave decoding byte addresses on aligned words.
`ifndef LWF_DEFS_SVH
`define LWF_DEFS_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define LWF_OFS_PIXEL_FIRST   8'h00
`define LWF_OFS_PIXEL_LAST    8'h2c
`define LWF_OFS_CTRL          8'h30
`define LWF_OFS_WAVE          8'h34
`define LWF_OFS_STATUS        8'h38
`define LWF_OFS_MASK          8'h3c
`define LWF_OFS_STATE         8'h40

// ==========================================================================
// Field positions
// ==========================================================================
`define LWF_CTRL_ENABLE       7
`define LWF_CTRL_SLEEP_STOP   6
`define LWF_CTRL_WRITE_ERROR_FLAG         5
`define LWF_CTRL_BIAS_EN      4
`define LWF_CTRL_CS_HI        3
`define LWF_CTRL_CS_LO        2
`define LWF_CTRL_MUX_HI       1
`define LWF_CTRL_MUX_LO       0
`define LWF_WAVE_TYPE_B       0
`define LWF_ST_FRAME          0
`define LWF_ST_WRITE_ERROR_FLAG           1

// ==========================================================================
// Reset values and codes
// ==========================================================================
`define LWF_CTRL_RESET        8'h13
`define LWF_WAVE_RESET        8'h00
`define LWF_MASK_RESET        2'h0
`define LWF_CS_SYSDIV         2'h0

// ==========================================================================
// Timing counts
// ==========================================================================
`define LWF_HALF_SLOT_CYCLES  16
`define LWF_IRQ_LEAD_HALVES   2

`endif

// File: verilog/lwf_pkg.sv
// Types shared by the segment display waveform block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package lwf_pkg;

    // ======================================================================
    // Multiplex modes and drive levels
    // ======================================================================
    typedef enum logic [1:0] {
        LWF_MUX_STATIC  = 2'b00,
        LWF_MUX_HALF    = 2'b01,
        LWF_MUX_THIRD   = 2'b10,
        LWF_MUX_QUARTER = 2'b11
    } lwf_mux_t;

    // Level 0 is the minimum display voltage, level 3 the maximum
    typedef logic [1:0] lwf_level_t;

    typedef struct packed {
        lwf_level_t [3:0]  com;
        lwf_level_t [17:0] segment_line;
    } lwf_drive_t;

    typedef struct packed {
        logic     enable;
        logic     sleep_stop;
        logic     write_error_flag;
        logic     bias_en;
        logic [1:0] cs;
        lwf_mux_t mux;
    } lwf_ctrl_t;

    typedef enum logic [1:0] {
        LWF_IDLE   = 2'b00,
        LWF_RUN    = 2'b01,
        LWF_HALTED = 2'b10
    } lwf_state_t;

endpackage

`default_nettype wire

// File: verilog/lwf_core.sv
// Segment display waveform generator with frame interrupt and write window.
// Assumes an APB master on pclk, and a sleep level from the core on pclk.
//
// Overview of operation
// - Each pixel sees zero net DC; dark gets higher rms, clear lower.
// - Commons carry their time slot; segments carry that slot's pixel bit.
// - Type-A inverts phase inside each slot; Type-B inverts per frame.
// - Static, half, third and quarter multiplex, each Type-A or Type-B.
// - A frame starts at the leading edge of common line zero.
// - Frame flag set when all pixel data fetched, a lead time before boundary.
// - Type-B frame interrupt only at the end of complete phase intervals.
// - Pixel write while writes are disabled is dropped and sets write error.
// - No frame interrupt for Type-A or for Type-B static drive.
// - With system clock /8192 source, sleep halts regardless of stop bit.
// - Segments 24 to 41: common n from three data registers, bit 0 up.
// - Sleep with stop bit set halts at once, all lines at minimum.
// - Clearing enable stops at frame end, or on leaving a halt; pins then go digital.
// - Asleep with frame interrupt enabled, wake at next frame boundary.
//
// The APB register port and the address map were chosen for this implementation.
`include "lwf_defs.svh"
`default_nettype none

module lwf_core
    import lwf_pkg::*;
#(
    parameter int HALF_SLOT_CYCLES = `LWF_HALF_SLOT_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    input  wire logic        sleep_req,
    output logic             wake,
    output logic             irq,
    output lwf_drive_t       drive,
    output logic             lines_oe
);

    // ======================================================================
    // Functions
    // ======================================================================
    function automatic logic [3:0] pixel_index(input logic [7:0] addr);
        pixel_index = 4'(addr[5:2]);
    endfunction

    function automatic logic is_pixel(input logic [7:0] addr);
        is_pixel = (addr[1:0] == 2'b00) && (addr <= `LWF_OFS_PIXEL_LAST);
    endfunction

    // Active common: phase picks V0 or V3; idle common sits at V1 or V2
    function automatic lwf_level_t com_level(input logic mux_static,
                                             input logic on_slot,
                                             input logic ph);
        if (on_slot || mux_static) begin
            com_level = ph ? 2'h3 : 2'h0;
        end else begin
            com_level = ph ? 2'h1 : 2'h2;
        end
    endfunction

    // Dark drives against the common, clear rides close to it
    function automatic lwf_level_t seg_level(input logic mux_static,
                                             input logic dark,
                                             input logic ph);
        if (mux_static) begin
            seg_level = (dark ^ ph) ? 2'h3 : 2'h0;
        end else if (dark) begin
            seg_level = ph ? 2'h0 : 2'h3;
        end else begin
            seg_level = ph ? 2'h2 : 2'h1;
        end
    endfunction

    // ======================================================================
    // Registers
    // ======================================================================
    logic [7:0]  pixel_reg [12];
    lwf_ctrl_t   ctrl_reg;
    logic        type_b_reg;
    logic [1:0]  status_reg;
    logic [1:0]  mask_reg;
    logic [1:0]  rd_status_reg;
    logic [31:0] prdata_reg;

    lwf_state_t  state_reg;
    logic [15:0] cyc_reg;
    logic        half_reg;
    logic [1:0]  slot_reg;
    logic        fphase_reg;
    logic        window_reg;
    logic [17:0] row_reg;
    lwf_drive_t  drive_reg;
    logic        wake_reg;

    logic        setup_ph;
    logic        access_ph;
    logic        wr_pix;
    logic        wr_ok;
    logic        wr_bad;
    logic        rd_status;
    logic        halt_req;
    logic        half_tick;
    logic        slot_end;
    logic        frame_end;
    logic        frame_irq_ev;
    logic        irq_gen_on;
    logic        phase;
    logic [1:0]  last_slot;
    logic [1:0]  next_slot;
    logic [7:0]  wbyte;

    // ======================================================================
    // APB decode
    // ======================================================================
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign pready    = 1'b1;
    assign wbyte     = pwdata[7:0];
    assign wr_pix    = access_ph && pwrite && is_pixel(paddr);
    assign rd_status = access_ph && !pwrite && (paddr == `LWF_OFS_STATUS);

    always_comb begin
        pslverr = 1'b0;
        if (access_ph && !is_pixel(paddr)) begin
            pslverr = !((paddr == `LWF_OFS_CTRL) || (paddr == `LWF_OFS_WAVE) ||
                        (paddr == `LWF_OFS_STATUS) || (paddr == `LWF_OFS_MASK) ||
                        (paddr == `LWF_OFS_STATE));
        end
    end

    // Writes are open unless Type-B multiplexed drive is outside its window
    assign irq_gen_on = type_b_reg && (ctrl_reg.mux != LWF_MUX_STATIC);
    assign wr_ok  = !irq_gen_on || window_reg;
    assign wr_bad = wr_pix && !wr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 12; i++) begin
                pixel_reg[i] <= 8'h00;
            end
        end else if (wr_pix && wr_ok) begin
            pixel_reg[pixel_index(paddr)] <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= lwf_ctrl_t'(`LWF_CTRL_RESET);
            type_b_reg <= 1'b0;
            mask_reg   <= `LWF_MASK_RESET;
        end else begin
            if (access_ph && pwrite && (paddr == `LWF_OFS_CTRL)) begin
                ctrl_reg <= lwf_ctrl_t'(wbyte);
                // Software may only clear the error; a new error still wins
                ctrl_reg.write_error_flag <= wbyte[`LWF_CTRL_WRITE_ERROR_FLAG] & ctrl_reg.write_error_flag;
            end
            if (wr_bad) begin
                ctrl_reg.write_error_flag <= 1'b1;
            end
            if (access_ph && pwrite && (paddr == `LWF_OFS_WAVE)) begin
                type_b_reg <= wbyte[`LWF_WAVE_TYPE_B];
            end
            if (access_ph && pwrite && (paddr == `LWF_OFS_MASK)) begin
                mask_reg <= wbyte[1:0];
            end
        end
    end

    // Read data is captured in the setup cycle; the status read clears only
    // the bits it returned, so an event landing in between is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg    <= 32'h0000_0000;
            rd_status_reg <= 2'h0;
        end else if (setup_ph && !pwrite) begin
            rd_status_reg <= status_reg;
            prdata_reg    <= 32'h0000_0000;
            if (is_pixel(paddr)) begin
                prdata_reg[7:0] <= pixel_reg[pixel_index(paddr)];
            end else begin
                case (paddr)
                    `LWF_OFS_CTRL:   prdata_reg[7:0] <= ctrl_reg;
                    `LWF_OFS_WAVE:   prdata_reg[0]   <= type_b_reg;
                    `LWF_OFS_STATUS: prdata_reg[1:0] <= status_reg;
                    `LWF_OFS_MASK:   prdata_reg[1:0] <= mask_reg;
                    `LWF_OFS_STATE:  prdata_reg[7:0] <= {state_reg, window_reg,
                                                         fphase_reg, slot_reg,
                                                         half_reg, lines_oe};
                    default:         prdata_reg      <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata = prdata_reg;

    // ======================================================================
    // Interrupt status
    // ======================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= 2'h0;
        end else begin
            status_reg <= (status_reg & ~(rd_status ? rd_status_reg : 2'h0)) |
                          {wr_bad, frame_irq_ev};
        end
    end

    assign irq = |(status_reg & mask_reg);

    // ======================================================================
    // Frame sequencer
    // ======================================================================
    // The /8192 source stops with the core, so sleep always halts it
    assign halt_req = sleep_req &&
                      (ctrl_reg.sleep_stop || (ctrl_reg.cs == `LWF_CS_SYSDIV));

    assign last_slot = 2'(ctrl_reg.mux);
    assign half_tick = (state_reg == LWF_RUN) && (cyc_reg == 16'(HALF_SLOT_CYCLES - 1));
    assign slot_end  = half_tick && half_reg;
    assign frame_end = slot_end && (slot_reg >= last_slot);
    assign next_slot = frame_end ? 2'h0 : 2'(slot_reg + 2'h1);

    // All rows are fetched on entering the last slot; Type-B raises only
    // in the second frame of a pair, ahead of the boundary closing a full phase interval
    assign frame_irq_ev = irq_gen_on && slot_end && fphase_reg &&
                          (next_slot == last_slot) && !frame_end;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= LWF_IDLE;
            cyc_reg    <= 16'h0000;
            half_reg   <= 1'b0;
            slot_reg   <= 2'h0;
            fphase_reg <= 1'b0;
        end else begin
            case (state_reg)
                LWF_IDLE: begin
                    cyc_reg    <= 16'h0000;
                    half_reg   <= 1'b0;
                    slot_reg   <= 2'h0;
                    fphase_reg <= 1'b0;
                    if (ctrl_reg.enable && !halt_req) begin
                        state_reg <= LWF_RUN;
                    end
                end
                LWF_RUN: begin
                    if (halt_req) begin
                        state_reg <= LWF_HALTED;
                    end else if (half_tick) begin
                        cyc_reg  <= 16'h0000;
                        half_reg <= !half_reg;
                        if (half_reg) begin
                            slot_reg <= next_slot;
                        end
                        if (frame_end) begin
                            fphase_reg <= !fphase_reg;
                            if (!ctrl_reg.enable) begin
                                state_reg <= LWF_IDLE;
                            end
                        end
                    end else begin
                        cyc_reg <= 16'(cyc_reg + 16'h0001);
                    end
                end
                LWF_HALTED: begin
                    if (!halt_req) begin
                        state_reg <= ctrl_reg.enable ? LWF_RUN : LWF_IDLE;
                    end
                end
                default: state_reg <= LWF_IDLE;
            endcase
        end
    end

    // Window runs from the frame flag to the following frame boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_reg <= 1'b0;
        end else if (frame_irq_ev) begin
            window_reg <= 1'b1;
        end else if (frame_end || state_reg != LWF_RUN) begin
            window_reg <= 1'b0;
        end
    end

    // Wake only for a live frame flag source with its mask bit set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= sleep_req && frame_end && irq_gen_on &&
                        mask_reg[`LWF_ST_FRAME];
        end
    end

    assign wake = wake_reg;

    // ======================================================================
    // Pixel fetch and waveform
    // ======================================================================
    always_comb begin
        row_reg = 18'h00000;
        for (int b = 0; b < 18; b++) begin
            row_reg[b] = pixel_reg[3 * int'(slot_reg) + b / 8][b % 8];
        end
    end

    // Type-A flips within the slot, Type-B holds it for a whole frame
    assign phase = type_b_reg ? fphase_reg : half_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_reg <= '0;
        end else if (state_reg != LWF_RUN || halt_req) begin
            drive_reg <= '0;
        end else begin
            for (int c = 0; c < 4; c++) begin
                drive_reg.com[c] <= com_level(ctrl_reg.mux == LWF_MUX_STATIC,
                                              slot_reg == 2'(c), phase);
            end
            for (int s = 0; s < 18; s++) begin
                drive_reg.segment_line[s] <= seg_level(ctrl_reg.mux == LWF_MUX_STATIC,
                                              row_reg[s], phase);
            end
        end
    end

    assign drive = drive_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lines_oe <= 1'b0;
        end else begin
            lines_oe <= (state_reg != LWF_IDLE);
        end
    end

endmodule

`default_nettype wire

// File: test/lwf_core_assertions.sv
// Port-level checker for the segment display waveform block.
// Assumes it is bound onto lwf_core and sees only that module's ports.
`include "lwf_defs.svh"
`default_nettype none

module lwf_core_assertions
    import lwf_pkg::*;
#(
    parameter int HALF_SLOT_CYCLES = 16
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        sleep_req,
    input wire logic        wake,
    input wire logic        irq,
    input wire lwf_drive_t  drive,
    input wire logic        lines_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Shadow of the mode registers, taken from the bus
    // ==========================================================
    // Margin of a few cycles covers the registered drive stage
    localparam int LEAD = 2 * HALF_SLOT_CYCLES + 4;
    lwf_ctrl_t ctl_q;
    logic      wave_q;
    logic      msk_q;
    logic      acc;
    logic      wr_msk;
    logic      rd_st;
    logic      c0_act;
    logic      halt_c;
    logic      st_c;
    assign acc    = psel && penable && pwrite;
    assign wr_msk = acc && paddr == `LWF_OFS_MASK;
    assign rd_st  = psel && penable && !pwrite && paddr == `LWF_OFS_STATUS;
    assign c0_act = drive.com[0] == 2'h0 || drive.com[0] == 2'h3;
    assign halt_c = sleep_req && lines_oe && (ctl_q.sleep_stop || ctl_q.cs == `LWF_CS_SYSDIV);
    assign st_c   = lines_oe && ctl_q.mux == LWF_MUX_STATIC;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q  <= lwf_ctrl_t'(`LWF_CTRL_RESET);
            wave_q <= 1'b0;
            msk_q  <= 1'b0;
        end else if (acc) begin
            if (paddr == `LWF_OFS_CTRL) ctl_q <= lwf_ctrl_t'(pwdata[7:0]);
            if (paddr == `LWF_OFS_WAVE) wave_q <= pwdata[0];
            if (wr_msk) msk_q <= pwdata[0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Properties
    // ==========================================================
    property p_irq_mode;
        $rose(irq) && !$past(wr_msk) |-> wave_q && ctl_q.mux != LWF_MUX_STATIC;
    endproperty
    a_irq_mode: assert property (p_irq_mode)
        else $error("frame irq outside Type-B multiplex");

    property p_irq_lead;
        $rose(irq) && !$past(wr_msk) |-> ##[1:LEAD] $rose(c0_act);
    endproperty
    a_irq_lead: assert property (p_irq_lead)
        else $error("no frame start within the lead time");

    property p_irq_hold;
        $fell(irq) |-> $past(rd_st || wr_msk);
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq dropped without a clear");

    property p_halt_zero;
        halt_c |-> ##[1:2] drive == '0;
    endproperty
    a_halt_zero: assert property (p_halt_zero)
        else $error("lines not at minimum after halt");

    property p_stop_end;
        $fell(lines_oe) |-> !ctl_q.enable;
    endproperty
    a_stop_end: assert property (p_stop_end)
        else $error("lines released while enabled");

    property p_stop_late;
        acc && paddr == `LWF_OFS_CTRL && !pwdata[`LWF_CTRL_ENABLE] && ctl_q.enable
            && lines_oe |=> lines_oe;
    endproperty
    a_stop_late: assert property (p_stop_late)
        else $error("lines released before frame end");

    property p_wake_cond;
        wake |-> $past(sleep_req) && msk_q && wave_q && ctl_q.mux != LWF_MUX_STATIC ##1 !wake;
    endproperty
    a_wake_cond: assert property (p_wake_cond)
        else $error("unexpected wake pulse");

    property p_static_lvl;
        st_c && $past(st_c, 3) |-> c0_act
            && (drive.segment_line[0] == drive.com[0] || drive.segment_line[0] == ~drive.com[0]);
    endproperty
    a_static_lvl: assert property (p_static_lvl)
        else $error("static segment not tied to common");
endmodule

bind lwf_core lwf_core_assertions #(.HALF_SLOT_CYCLES(HALF_SLOT_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .sleep_req(sleep_req), .wake(wake), .irq(irq), .drive(drive), .lines_oe(lines_oe)
);

`default_nettype wire

// File: test/lwf_panel.sv
// Passive glass model: integrates two pixels on common line zero.
// Assumes levels 0..3 and that released lines put no charge on the glass.
`default_nettype none

module lwf_panel
    import lwf_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       clr,
    input  wire lwf_drive_t drive,
    input  wire logic       lines_oe,
    output int              dc_dark,
    output int              dc_clear,
    output int              sq_dark,
    output int              sq_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    int v_d;
    int v_c;
    // Segment 24 carries the dark pixel, segment 25 the clear one
    assign v_d = int'(drive.com[0]) - int'(drive.segment_line[0]);
    assign v_c = int'(drive.com[0]) - int'(drive.segment_line[1]);

    always_ff @(posedge pclk) begin
        if (clr) begin
            dc_dark  <= 0;
            dc_clear <= 0;
            sq_dark  <= 0;
            sq_clear <= 0;
        end else if (lines_oe) begin
            dc_dark  <= dc_dark + v_d;
            dc_clear <= dc_clear + v_c;
            sq_dark  <= sq_dark + v_d * v_d;
            sq_clear <= sq_clear + v_c * v_c;
        end
    end
endmodule

`default_nettype wire

// File: test/lwf_core_tb.sv
// Self-checking bench: register traffic, frame timing, errors and sleep.
// Assumes lwf_core with its bound checker and the lwf_panel glass model.
`include "lwf_defs.svh"
`default_nettype none

module lwf_core_tb
    import lwf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int H = 4;
    localparam int F = 8 * H;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        sleep_req;
    logic        clr;
    logic        pready;
    logic        pslverr;
    logic        wake;
    logic        irq;
    logic        lines_oe;
    logic        err;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] q;
    logic [2:0]  ev;
    lwf_drive_t  drive;
    int          dc_d, dc_c, sq_d, sq_c;
    int          bad_count;
    int          n_checks;
    assign ev = {!lines_oe, wake, irq};

    lwf_core #(.HALF_SLOT_CYCLES(H)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .sleep_req(sleep_req), .wake(wake), .irq(irq), .drive(drive), .lines_oe(lines_oe)
    );
    lwf_panel u_panel (
        .pclk(pclk), .clr(clr), .drive(drive), .lines_oe(lines_oe),
        .dc_dark(dc_d), .dc_clear(dc_c), .sq_dark(sq_d), .sq_clear(sq_c)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic guard(input logic ok);
        if (!ok) begin
            bad_count++;
            $display("wrong value at %0t: wait ran out", $time);
            conclude();
        end
    endtask

    // Idle cycle after each transfer keeps every strobe to one change per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        guard(n < 50);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0);
        check(q, want);
    endtask

    task automatic wait_ev(input int k);
        int n;
        n = 0;
        while (ev[k] !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        guard(n < 400);
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {presetn, psel, penable, pwrite, sleep_req, clr, paddr, pwdata} = '0;
        bad_count = 0;
        n_checks  = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(`LWF_OFS_CTRL, 32'h13);
        rchk(`LWF_OFS_MASK, 32'h0);
        apb(1'b0, 8'h44, 32'h0);
        check({31'h0, err}, 32'h1);
        check(q, 32'h0);
        for (int i = 0; i < 12; i++) apb(1'b1, 8'(4 * i), 32'(8'ha5 ^ 8'(i)));
        for (int i = 0; i < 12; i++) rchk(8'(4 * i), 32'(8'ha5 ^ 8'(i)));
        apb(1'b1, 8'h00, 32'h01);
        apb(1'b1, `LWF_OFS_MASK, 32'h1);
        $display("test registers finished");
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, `LWF_OFS_WAVE, 32'(m[2]));
            apb(1'b1, `LWF_OFS_CTRL, 32'h94 | 32'(m[1:0]));
            repeat (F) @(posedge pclk);
            apb(1'b0, `LWF_OFS_STATUS, 32'h0);
            if (m == 0) begin
                check(32'(drive.segment_line[0] == ~drive.com[0]), 1);
                check(32'(drive.segment_line[8] == drive.com[0]), 1);
                check(32'(drive.segment_line[16] == ~drive.com[0]), 1);
            end
            clr <= 1'b1;
            @(posedge pclk);
            clr <= 1'b0;
            repeat (4 * H * (m[1:0] + 1) + 1) @(posedge pclk);
            check(32'(dc_d), 0);
            check(32'(dc_c), 0);
            check(32'(sq_d > sq_c), 1);
            rchk(`LWF_OFS_STATUS, 32'(m[2] && m[1:0] != 2'h0));
        end
        $display("test waveforms finished");
        apb(1'b0, `LWF_OFS_STATUS, 32'h0);
        wait_ev(0);
        apb(1'b1, 8'h2c, 32'h33);
        rchk(`LWF_OFS_CTRL, 32'h97);
        repeat (2 * H) @(posedge pclk);
        apb(1'b1, 8'h2c, 32'hcc);
        rchk(8'h2c, 32'h33);
        rchk(`LWF_OFS_CTRL, 32'hb7);
        check({31'h0, irq}, 32'h1);
        rchk(`LWF_OFS_STATUS, 32'h3);
        check({31'h0, irq}, 32'h0);
        wait_ev(0);
        apb(1'b1, `LWF_OFS_CTRL, 32'h97);
        apb(1'b1, `LWF_OFS_MASK, 32'h0);
        apb(1'b0, `LWF_OFS_STATUS, 32'h0);
        repeat (2 * F) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rchk(`LWF_OFS_STATUS, 32'h1);
        $display("test frame flag finished");
        apb(1'b1, `LWF_OFS_MASK, 32'h1);
        sleep_req <= 1'b1;
        wait_ev(1);
        sleep_req <= 1'b0;
        check({31'h0, lines_oe}, 32'h1);
        apb(1'b1, `LWF_OFS_CTRL, 32'h17);
        wait_ev(2);
        $display("test wake and disable finished");
        for (int k = 0; k < 2; k++) begin
            presetn <= 1'b0;
            @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            apb(1'b1, `LWF_OFS_CTRL, (k == 1) ? 32'hd7 : 32'h93);
            repeat (F) @(posedge pclk);
            sleep_req <= 1'b1;
            repeat (3) @(posedge pclk);
            check(32'(drive == '0), 1);
            check({31'h0, lines_oe}, 32'h1);
            sleep_req <= 1'b0;
        end
        $display("test halt finished");
        conclude();
    end
endmodule

`default_nettype wire
